/* inc/pin_irq_pkg.sv */
`default_nettype none
package pin_irq_pkg;
  localparam int PIN_COUNT = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register map: word index on the plain register port
  localparam logic [3:0] REG_EDGE_BASE = 4'h0; // 0x0..0x7 edge type per pin
  localparam logic [3:0] REG_STATUS = 4'h8;    // read clears pending bits
  localparam logic [3:0] REG_SNAP = 4'h9;      // snapshot of last events
  localparam logic [3:0] REG_PINS = 4'ha;      // synchronised pin levels
  localparam logic [3:0] REG_LAST = 4'ha;
  localparam logic [1:0] EDGE_TYPE_RESET = 2'h0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // edge type encoding
  typedef enum logic [1:0] {
    EDGE_OFF = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_ANY = 2'h3
  } pin_edge_type_e;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage
`default_nettype wire

/* hw/pin_edge_detect.sv */
`default_nettype none
module pin_edge_detect
  import pin_irq_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset
  input wire logic pin_in, // raw pin level
  input wire pin_edge_type_e edge_type, // edge selection
  output logic pin_sync, // synchronised level
  output logic hit // selected edge seen, one cycle
);
  logic meta;
  logic prev;
  logic rise;
  logic fall;
  logic [2:0] fill;

  // --------------------------------
  // two-flop synchroniser and history
  // --------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta <= 1'b0;
      pin_sync <= 1'b0;
      prev <= 1'b0;
      fill <= 3'h0;
    end
    else
    begin
      meta <= pin_in;
      pin_sync <= meta;
      prev <= pin_sync;
      fill <= {fill[1:0], 1'b1};
    end
  end

  // no false edge while the history refills after reset
  assign rise = pin_sync & ~prev & fill[2];
  assign fall = ~pin_sync & prev & fill[2];

  // --------------------------------
  // edge select, no level mode exists
  // --------------------------------
  always_comb
  begin
    case (edge_type)
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_ANY: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* hw/port_pin_irq_unit.sv */
// Our own choices: the strobed register port and the register addresses.
`default_nettype none
module port_pin_irq_unit
  import pin_irq_pkg::*;
#(
  parameter int PINS = PIN_COUNT
)
(
  input wire logic clk_sys, // system clock, never gated here
  input wire logic srst, // sync reset, active high
  input wire logic [PINS-1:0] pin_in, // port pin levels
  input wire logic [pin_irq_pkg::ADDR_W-1:0] reg_addr, // register index
  input wire logic [pin_irq_pkg::DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [pin_irq_pkg::DATA_W-1:0] reg_rdata, // read data, next cycle
  input wire logic wake_in, // wake from previous unit
  output logic wake_out, // wake toward next unit
  output logic port_irq_request // combined interrupt request
);
  import pin_irq_pkg::*;

  reg_req_s req;
  pin_edge_type_e edge_type [PINS];
  logic [PINS-1:0] hit;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] status;
  logic [PINS-1:0] snap;
  logic [PINS-1:0] event_set;
  logic [PINS-1:0] next_status;
  logic status_rd;
  logic edge_wr;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign status_rd = req.rd && (req.addr == REG_STATUS);
  assign edge_wr = req.wr && (req.addr < (REG_EDGE_BASE + 4'(PINS)));

  // --------------------------------
  // per-pin edge type and detector
  // --------------------------------
  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_pin
      always_ff @(posedge clk_sys)
      begin
        if (srst)
          edge_type[g] <= pin_edge_type_e'(EDGE_TYPE_RESET);
        else if (edge_wr && (req.addr == (REG_EDGE_BASE + 4'(g))))
          edge_type[g] <= pin_edge_type_e'(req.wdata[1:0]);
      end

      pin_edge_detect u_det (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(pin_in[g]),
        .edge_type(edge_type[g]),
        .pin_sync(pin_sync[g]),
        .hit(hit[g])
      );
    end
  endgenerate

  // --------------------------------
  // status: read clears, set wins for pins not pending
  // --------------------------------
  // a pending pin ignores edges in the read cycle itself
  assign event_set = hit & ~(status & {PINS{status_rd}});

  always_comb
  begin
    next_status = status;
    if (status_rd)
      next_status = '0;
    next_status = next_status | event_set;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      status <= STATUS_RESET[PINS-1:0];
    else
      status <= next_status;
  end

  // snapshot follows the same events
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      snap <= STATUS_RESET[PINS-1:0];
    else if (|event_set)
      snap <= event_set;
  end

  // --------------------------------
  // request and wake chain
  // --------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      port_irq_request <= 1'b0;
    else
      port_irq_request <= |next_status;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      wake_out <= 1'b0;
    else
      wake_out <= wake_in | (|event_set);
  end

  // --------------------------------
  // register read port
  // --------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      reg_rdata <= READ_ZERO;
    else if (req.rd)
    begin
      reg_rdata <= READ_ZERO;
      if (req.addr < (REG_EDGE_BASE + 4'(PINS)))
        reg_rdata <= {6'h00, edge_type[req.addr[2:0]]};
      else if (req.addr == REG_STATUS)
        reg_rdata <= DATA_W'(status);
      else if (req.addr == REG_SNAP)
        reg_rdata <= DATA_W'(snap);
      else if (req.addr == REG_PINS)
        reg_rdata <= DATA_W'(pin_sync);
    end
    else
      reg_rdata <= READ_ZERO;
  end

  // --------------------------------
  // checks
  // --------------------------------
  sequence s_read_pending;
    status_rd && (status != '0);
  endsequence

  sequence s_cleared;
    ##1 ((status & $past(status)) == '0);
  endsequence

  AST_READ_CLEARS: assert property (@(posedge clk_sys) disable iff (srst)
    s_read_pending |-> s_cleared)
    else $error("status read did not clear pending bits");

  AST_EDGE_SETS: assert property (@(posedge clk_sys) disable iff (srst)
    (hit != '0 && !status_rd) |=> ((status & $past(hit)) == $past(hit)))
    else $error("detected edge did not set status");

  AST_REQ_HOLDS: assert property (@(posedge clk_sys) disable iff (srst)
    (status != '0) |-> port_irq_request)
    else $error("request low while status pending");

  AST_REQ_IDLE: assert property (@(posedge clk_sys) disable iff (srst)
    (status == '0) |-> !port_irq_request)
    else $error("request high with no status");

  AST_WAKE_OR: assert property (@(posedge clk_sys) disable iff (srst)
    wake_out == $past(wake_in | (|event_set)))
    else $error("wake output not OR of input and events");

  AST_SNAP: assert property (@(posedge clk_sys) disable iff (srst)
    (event_set != '0) |=> (snap == $past(event_set)))
    else $error("snapshot missed an event");

  AST_NO_LEVEL: assert property (@(posedge clk_sys) disable iff (srst)
    $stable(pin_sync) && !status_rd |=> (status == $past(status)))
    else $error("status changed without an edge");

  AST_OFF_PIN: assert property (@(posedge clk_sys) disable iff (srst)
    (edge_type[0] == EDGE_OFF) |-> !hit[0])
    else $error("disabled pin produced an event");

  AST_RDATA_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
    !req.rd |=> (reg_rdata == READ_ZERO))
    else $error("read data outside read answer cycle");

  // a read answer carries the register sampled with the strobe
  AST_RD_STATUS: assert property (@(posedge clk_sys) disable iff (srst)
    status_rd |=> (reg_rdata == DATA_W'($past(status))))
    else $error("status read answer wrong");

  AST_RD_SNAP: assert property (@(posedge clk_sys) disable iff (srst)
    (req.rd && (req.addr == REG_SNAP)) |=> (reg_rdata == DATA_W'($past(snap))))
    else $error("snapshot read answer wrong");

  AST_RD_PINS: assert property (@(posedge clk_sys) disable iff (srst)
    (req.rd && (req.addr == REG_PINS)) |=> (reg_rdata == DATA_W'($past(pin_sync))))
    else $error("pin level read answer wrong");

  AST_RD_UNMAPPED: assert property (@(posedge clk_sys) disable iff (srst)
    (req.rd && (req.addr > REG_PINS)) |=> (reg_rdata == READ_ZERO))
    else $error("unmapped read returned data");

  AST_STATUS_SRC: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> ((status & ~$past(status) & ~$past(event_set)) == '0))
    else $error("status bit set with no event");

  AST_STATUS_RO: assert property (@(posedge clk_sys) disable iff (srst)
    (req.wr && !status_rd && (hit == '0)) |=> (status == $past(status)))
    else $error("register write altered status");

  AST_SNAP_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
    (event_set == '0) |=> $stable(snap))
    else $error("snapshot changed with no event");

  AST_REQ_RISE: assert property (@(posedge clk_sys) disable iff (srst)
    (event_set != '0) |=> port_irq_request)
    else $error("event did not raise the request");

  sequence s_quiet_read;
    status_rd && (hit == '0);
  endsequence

  AST_REQ_DROP: assert property (@(posedge clk_sys) disable iff (srst)
    s_quiet_read |=> !port_irq_request)
    else $error("request stayed high after a quiet status read");

  AST_WAKE_EVENT: assert property (@(posedge clk_sys) disable iff (srst)
    (event_set != '0) |=> wake_out)
    else $error("event did not raise wake output");

  AST_WAKE_IDLE: assert property (@(posedge clk_sys) disable iff (srst)
    (!wake_in && (event_set == '0)) |=> !wake_out)
    else $error("wake output high with no cause");

  AST_WAKE_PASS: assert property (@(posedge clk_sys) disable iff (srst)
    wake_in |=> wake_out)
    else $error("wake input not passed along the chain");

  // --------------------------------
  // per-pin checks
  // --------------------------------
  generate
    for (g = 0; g < PINS; g++)
    begin : g_chk
      sequence s_pin_pending;
        status_rd && status[g];
      endsequence

      sequence s_pin_free_hit;
        status_rd && !status[g] && hit[g];
      endsequence

      AST_PIN_BLOCKED: assert property (@(posedge clk_sys) disable iff (srst)
        s_pin_pending |=> !status[g])
        else $error("pending pin took an edge during status read");

      AST_PIN_FREE: assert property (@(posedge clk_sys) disable iff (srst)
        s_pin_free_hit |=> status[g])
        else $error("free pin lost an edge during status read");

      AST_PIN_RISE: assert property (@(posedge clk_sys) disable iff (srst)
        (hit[g] && (edge_type[g] == EDGE_RISE)) |-> pin_sync[g])
        else $error("rising mode fired on a falling pin");

      AST_PIN_FALL: assert property (@(posedge clk_sys) disable iff (srst)
        (hit[g] && (edge_type[g] == EDGE_FALL)) |-> !pin_sync[g])
        else $error("falling mode fired on a rising pin");

      AST_PIN_EDGE_ONLY: assert property (@(posedge clk_sys) disable iff (srst)
        hit[g] |-> $changed(pin_sync[g]))
        else $error("event without a pin change");

      AST_PIN_OFF: assert property (@(posedge clk_sys) disable iff (srst)
        (edge_type[g] == EDGE_OFF) |-> !hit[g])
        else $error("disabled pin fired an event");

      AST_PIN_CFG: assert property (@(posedge clk_sys) disable iff (srst)
        (edge_wr && (req.addr == (REG_EDGE_BASE + 4'(g))))
          |=> (edge_type[g] == pin_edge_type_e'($past(req.wdata[1:0]))))
        else $error("edge type write did not land");

      AST_PIN_CFG_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
        !(edge_wr && (req.addr == (REG_EDGE_BASE + 4'(g)))) |=> $stable(edge_type[g]))
        else $error("edge type changed without a write");

      AST_PIN_RD_CFG: assert property (@(posedge clk_sys) disable iff (srst)
        (req.rd && (req.addr == (REG_EDGE_BASE + 4'(g))))
          |=> (reg_rdata == {6'h00, $past(edge_type[g])}))
        else $error("edge type read answer wrong");
    end
  endgenerate
endmodule
`default_nettype wire

/* bench/wake_sink.sv */
`default_nettype none
// ----------------------------------------
// power manager end of the wake chain
// ----------------------------------------
module wake_sink
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset
  input wire logic wake, // last wake output of chain
  output var int wake_cycles // cycles with wake high
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      wake_cycles <= 0;
    else if (wake)
      wake_cycles <= wake_cycles + 1;
  end
endmodule
`default_nettype wire

/* bench/port_pin_irq_unit_tb.sv */
`default_nettype none
module port_pin_irq_unit_tb
  import pin_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, wake_in = 1'b0;
  logic [7:0] pin_in = 8'h00, reg_wdata = 8'h00, rd_val, reg_rdata;
  logic [3:0] reg_addr = 4'h0;
  logic wake_out, port_irq_request;
  logic [31:0] lfsr = 32'h9c8f59dd;
  int failures = 0, samples_checked = 0, wake_cycles, w0;
  always #4 clk_sys = ~clk_sys;
  port_pin_irq_unit uut (.clk_sys(clk_sys), .srst(srst), .pin_in(pin_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_in(wake_in), .wake_out(wake_out), .port_irq_request(port_irq_request));
  wake_sink sink (.clk_sys(clk_sys), .srst(srst), .wake(wake_out), .wake_cycles(wake_cycles));
  // ----------------------------------------
  // expectation helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_status(input logic [1:0] c, input logic r, input int p);
    return (r ? c[0] : c[1]) ? 8'h01 << p : 8'h00;
  endfunction
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h got %h", n, e, g);
      failures++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one pin: program code, rise then fall, check status, snapshot, wake
  task automatic edge_case(input int p, input logic [1:0] code);
    logic [7:0] e;
    wr(REG_EDGE_BASE + 4'(p), {6'h00, code});
    rd(REG_EDGE_BASE + 4'(p), rd_val);
    chk("edge_type", {6'h00, code}, rd_val);
    for (int r = 1; r >= 0; r--)
    begin
      e = exp_status(code, r[0], p);
      w0 = wake_cycles;
      @(posedge clk_sys);
      pin_in[p] <= r[0];
      repeat (6) @(posedge clk_sys);
      #1 chk("irq", {7'h00, |e}, {7'h00, port_irq_request});
      chk("wake", {7'h00, |e}, 8'(wake_cycles - w0));
      rd(REG_PINS, rd_val);
      chk("pins", r[0] ? 8'h01 << p : 8'h00, rd_val);
      rd(REG_STATUS, rd_val);
      chk("status", e, rd_val);
      chk("irq_clr", 8'h00, {7'h00, port_irq_request});
      if (|e)
      begin
        rd(REG_SNAP, rd_val);
        chk("snapshot", e, rd_val);
      end
      rd(REG_STATUS, rd_val);
      chk("status_clr", 8'h00, rd_val);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    rd(REG_STATUS, rd_val);
    chk("status_rst", STATUS_RESET, rd_val);
    rd(4'hb, rd_val);
    chk("unmapped", READ_ZERO, rd_val);
    wr(REG_STATUS, 8'hff);
    rd(REG_STATUS, rd_val);
    chk("status_ro", 8'h00, rd_val);
    for (int c = 0; c < 4; c++)
      edge_case(c * 2 + 1, 2'(c));
    for (int i = 0; i < 8; i++)
    begin
      lfsr = lfsr_next(lfsr);
      edge_case(int'(lfsr[2:0]), lfsr[4:3]);
    end
    // pin 0 pending, then pin 0 and pin 2 edges land on the status read edge
    wr(REG_EDGE_BASE, {6'h00, EDGE_ANY});
    wr(REG_EDGE_BASE + 4'h2, {6'h00, EDGE_ANY});
    @(posedge clk_sys);
    pin_in[0] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    pin_in <= 8'h04;
    @(posedge clk_sys);
    rd(REG_STATUS, rd_val);
    chk("status_block", 8'h01, rd_val);
    rd(REG_STATUS, rd_val);
    chk("status_free", 8'h04, rd_val);
    @(posedge clk_sys);
    pin_in <= 8'h00;
    repeat (6) @(posedge clk_sys);
    rd(REG_STATUS, rd_val);
    chk("status_fall", 8'h04, rd_val);
    @(posedge clk_sys);
    wake_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("wake_chain", 8'h01, {7'h00, wake_out});
    @(posedge clk_sys);
    wake_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("wake_idle", 8'h00, {7'h00, wake_out});
    test_done;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
